// ===== logic/deac_ctrl.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// RULE1: 128 byte cells at 0h..7Fh, single byte read and program.
// RULE2: each program erases the location then stores the new byte.
// RULE3: program length set by internal timer; done only on expiry.
// RULE4: code protection blocks external programmer, not the CPU.
// RULE5: cell_byte holds data to program or read result, resets zero.
// RULE6: only low seven index bits address; top bit ignored.
// RULE7: software keeps index top bit at zero.
// RULE8: control register has four bits; upper four read zero.
// RULE9: triggers are set-only by software, cleared by hardware.
// RULE10: programming only while unlock gate set; gate clear at power-up.
// RULE11: abort flag set when reset interrupts a program cycle.
// RULE12: reset aborting a program clears cell_byte and cell_index.
// RULE13: completion sets done flag bit 7 at 0Ch; software clears it.
// RULE14: unlock port stores nothing, reads zero, feeds unlock sequence.
// RULE15: read completes in one cycle; byte held until next update.
// RULE16: program starts only after 55h, AAh, then trigger, timed.
// RULE17: trigger blocked without gate; later gate clear harmless.
// RULE18: done flag has enable bit that raises interrupt request.
// RULE19: control bits abort 3, gate 2, program 1, fetch 0.
// RULE20: triggers ignored while a program cycle runs.
module deac_ctrl
  import deac_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
)(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                resetMasterClear,
  input  wire logic                resetWatchdog,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [DATA_W-1:0]   prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     peripheralIrq,
  output logic                     programBusy,
  input  wire logic                codeProtect,
  input  wire logic [CELL_AW-1:0]  extIndex,
  output logic      [7:0]          extByte
);
  import deac_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]            cellByte_ff, nxt_cellByte;
  logic [CELL_AW-1:0]    cellIndex_ff, nxt_cellIndex;
  logic                  fetch_ff, nxt_fetch;
  logic                  prog_ff, nxt_prog;
  logic                  gate_ff, nxt_gate;
  logic                  abort_ff, nxt_abort;
  logic                  done_ff, nxt_done;
  logic                  doneIe_ff, nxt_doneIe;
  deac_seq_type          seq_ff, nxt_seq;
  logic [GAP_CNT_W-1:0]  gap_ff, nxt_gap;
  logic [PROG_CNT_W-1:0] progCnt_ff, nxt_progCnt;
  logic [CELL_AW-1:0]    progIdx_ff, nxt_progIdx;
  logic [7:0]            progByte_ff, nxt_progByte;
  logic [DATA_W-1:0]     prdata_ff, nxt_prdata;
  logic                  pslverr_ff, nxt_pslverr;
  logic [7:0]            extByteReg_ff, nxt_extByte;

  logic       resetEvt, setupPh, accessPh, wrAcc, mapped, lowOk;
  logic [7:0] wrByte, rdByte, arrRdByte, ctrlView, regIdx;
  logic       progStart, progEnd, eraseEn;
  logic [CELL_AW-1:0] arrRdIdx;

  assign resetEvt = resetMasterClear | resetWatchdog;
  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign regIdx   = paddr[9:2];
  assign lowOk    = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign wrByte   = pwdata[7:0];
  assign wrAcc    = accessPh & pwrite & ~pslverr_ff & pstrb[0];
  assign ctrlView = {4'h0, abort_ff, gate_ff, prog_ff, fetch_ff};

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  // external port shares the read path only while no CPU fetch is due
  assign arrRdIdx = fetch_ff ? cellIndex_ff : extIndex;
  assign rdByte   = arrRdByte;

  deac_cell_array u_cells (
    .clock     (clock),
    .rst       (rst),
    .rdIndex   (arrRdIdx),
    .rdByte    (arrRdByte),
    .wrIndex   (progIdx_ff),
    .eraseEn   (eraseEn),
    .storeEn   (progEnd),
    .storeByte (progByte_ff)
  );

  // ----------------------------------------------------------------
  // address decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (setupPh) begin
      nxt_prdata = '0;
      case (regIdx)
        IDX_FLAGS:  nxt_prdata[DONE_BIT] = done_ff;
        IDX_IRQEN:  nxt_prdata[DONE_IE_BIT] = doneIe_ff;
        IDX_DATA:   nxt_prdata[7:0] = cellByte_ff;
        IDX_INDEX:  nxt_prdata[CELL_AW-1:0] = cellIndex_ff;
        // RULE8: upper bits zero
        IDX_CTRL:   nxt_prdata[7:0] = ctrlView;
        // RULE14: reads zero
        IDX_UNLOCK: nxt_prdata = '0;
        default:    mapped = 1'b0;
      endcase
      nxt_pslverr = ~(mapped & lowOk);
    end
  end

  // ----------------------------------------------------------------
  // unlock sequence tracker
  // ----------------------------------------------------------------
  always_comb begin
    nxt_seq = seq_ff;
    nxt_gap = gap_ff;
    if (seq_ff != SEQ_IDLE) begin
      nxt_gap = gap_ff + 4'h1;
    end
    // RULE16: strict order and timing
    if (seq_ff != SEQ_IDLE && gap_ff >= GAP_CNT_W'(UNLOCK_GAP_CYC)) begin
      nxt_seq = SEQ_IDLE;
    end
    if (accessPh) begin
      nxt_gap = '0;
      nxt_seq = SEQ_IDLE;
      if (wrAcc && regIdx == IDX_UNLOCK) begin
        if (wrByte == UNLOCK_KEY1 && seq_ff == SEQ_IDLE) begin
          nxt_seq = SEQ_GOT_KEY1;
        end else if (wrByte == UNLOCK_KEY2 && seq_ff == SEQ_GOT_KEY1) begin
          nxt_seq = SEQ_GOT_KEY2;
        end
      end
    end
    // reset event cancels a half-done unlock
    if (resetEvt) begin
      nxt_seq = SEQ_IDLE;
    end
  end

  // RULE10: gate must already be set
  // RULE17: trigger blocked without gate
  // RULE20: no restart while busy
  assign progStart = wrAcc && regIdx == IDX_CTRL && wrByte[PROG_BIT]
                     && gate_ff && seq_ff == SEQ_GOT_KEY2 && !prog_ff;
  // RULE3: completion only on timer expiry
  assign progEnd   = prog_ff && progCnt_ff == '0 && !resetEvt;
  // RULE2: erase in the first timed cycle, store at the last
  assign eraseEn   = prog_ff && progCnt_ff == PROG_CNT_W'(PROG_CYC - 1)
                     && !resetEvt;

  // ----------------------------------------------------------------
  // register and control next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cellByte  = cellByte_ff;
    nxt_cellIndex = cellIndex_ff;
    nxt_fetch     = 1'b0;
    nxt_prog      = prog_ff;
    nxt_gate      = gate_ff;
    nxt_abort     = abort_ff;
    nxt_done      = done_ff;
    nxt_doneIe    = doneIe_ff;
    nxt_progCnt   = progCnt_ff;
    nxt_progIdx   = progIdx_ff;
    nxt_progByte  = progByte_ff;
    // RULE15: one-cycle read, held after
    if (fetch_ff) begin
      nxt_cellByte = rdByte;
    end
    if (prog_ff && progCnt_ff != '0) begin
      nxt_progCnt = progCnt_ff - 1'b1;
    end
    if (wrAcc) begin
      case (regIdx)
        IDX_FLAGS: nxt_done = wrByte[DONE_BIT];
        IDX_IRQEN: nxt_doneIe = wrByte[DONE_IE_BIT];
        // RULE5: full byte read/write
        IDX_DATA:  nxt_cellByte = wrByte;
        // RULE6: top index bit dropped
        IDX_INDEX: nxt_cellIndex = wrByte[CELL_AW-1:0];
        IDX_CTRL: begin
          // RULE19: control bit layout
          nxt_gate  = wrByte[GATE_BIT];
          nxt_abort = wrByte[ABORT_BIT];
          // RULE20: read ignored while programming
          nxt_fetch = wrByte[FETCH_BIT] & ~prog_ff;
        end
        default: nxt_done = done_ff;
      endcase
    end
    if (progStart) begin
      nxt_prog     = 1'b1;
      nxt_progCnt  = PROG_CNT_W'(PROG_CYC - 1);
      nxt_progIdx  = cellIndex_ff;
      nxt_progByte = cellByte_ff;
    end
    // RULE9: only the timer or a reset event clears the program bit
    // RULE13: set wins over software clear
    if (progEnd) begin
      nxt_prog = 1'b0;
      nxt_done = 1'b1;
    end
    if (resetEvt) begin
      // RULE11: abort flag on interrupted cycle
      nxt_abort     = abort_ff | prog_ff;
      // RULE12: data and index cleared
      nxt_cellByte  = RST_BYTE;
      nxt_cellIndex = '0;
      nxt_fetch     = 1'b0;
      nxt_prog      = 1'b0;
      nxt_gate      = 1'b0;
      nxt_done      = 1'b0;
      nxt_doneIe    = 1'b0;
      nxt_progCnt   = '0;
    end
  end

  // RULE4: programmer view blanked under protection
  always_comb begin
    nxt_extByte = codeProtect ? 8'h00 : arrRdByte;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cellByte_ff   <= RST_BYTE;
      cellIndex_ff  <= '0;
      fetch_ff      <= 1'b0;
      prog_ff       <= 1'b0;
      gate_ff       <= 1'b0;
      abort_ff      <= 1'b0;
      done_ff       <= 1'b0;
      doneIe_ff     <= 1'b0;
      seq_ff        <= SEQ_IDLE;
      gap_ff        <= '0;
      progCnt_ff    <= '0;
      progIdx_ff    <= '0;
      progByte_ff   <= RST_BYTE;
      prdata_ff     <= '0;
      pslverr_ff    <= 1'b0;
      extByteReg_ff <= 8'h00;
    end else begin
      cellByte_ff   <= nxt_cellByte;
      cellIndex_ff  <= nxt_cellIndex;
      fetch_ff      <= nxt_fetch;
      prog_ff       <= nxt_prog;
      gate_ff       <= nxt_gate;
      abort_ff      <= nxt_abort;
      done_ff       <= nxt_done;
      doneIe_ff     <= nxt_doneIe;
      seq_ff        <= nxt_seq;
      gap_ff        <= nxt_gap;
      progCnt_ff    <= nxt_progCnt;
      progIdx_ff    <= nxt_progIdx;
      progByte_ff   <= nxt_progByte;
      prdata_ff     <= nxt_prdata;
      pslverr_ff    <= nxt_pslverr;
      extByteReg_ff <= nxt_extByte;
    end
  end

  assign prdata      = prdata_ff;
  assign pslverr     = accessPh & pslverr_ff;
  assign pready      = accessPh;
  assign programBusy = prog_ff;
  assign extByte     = extByteReg_ff;
  // RULE18: enable gates the completion request
  assign peripheralIrq = done_ff & doneIe_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_fetch_loads_byte: assert property ( // RULE15
    fetch_ff && !resetEvt |=> cellByte_ff == $past(arrRdByte)
      && !fetch_ff)
    else $error("read did not load cell byte in one cycle");
  a_prog_gate_req: assert property ( // RULE10
    $rose(prog_ff) |-> $past(gate_ff))
    else $error("program started without unlock gate");
  a_prog_seq_req: assert property ( // RULE16
    $rose(prog_ff) |-> $past(seq_ff) == SEQ_GOT_KEY2)
    else $error("program started without unlock sequence");
  a_prog_holds: assert property ( // RULE9
    prog_ff && progCnt_ff != '0 && !resetEvt |=> prog_ff)
    else $error("program bit cleared before timer expiry");
  a_done_on_end: assert property ( // RULE13
    progEnd |=> done_ff && !prog_ff)
    else $error("completion did not set done flag");
  a_ctrl_upper_zero: assert property ( // RULE8
    setupPh && regIdx == IDX_CTRL |=> prdata_ff[DATA_W-1:4] == '0)
    else $error("control upper bits not zero");
  a_unlock_reads_zero: assert property ( // RULE14
    setupPh && regIdx == IDX_UNLOCK |=> prdata_ff == '0)
    else $error("unlock port read not zero");
  a_abort_clears: assert property ( // RULE11
    resetEvt && prog_ff |=> abort_ff && cellByte_ff == RST_BYTE
      && cellIndex_ff == '0 && !prog_ff)
    else $error("interrupted program not flagged and cleared");
  a_no_restart_busy: assert property ( // RULE20
    prog_ff && !progEnd && !resetEvt |=> $stable(progIdx_ff))
    else $error("new program accepted while busy");
  a_irq_follows: assert property ( // RULE18
    progEnd && doneIe_ff && !(wrAcc && regIdx == IDX_IRQEN)
      |=> peripheralIrq)
    else $error("interrupt request missing");

  c_read_done: cover property (fetch_ff ##1 !fetch_ff);
  c_prog_done: cover property (progEnd ##1 done_ff);
  c_prog_abort: cover property (prog_ff && resetEvt ##1 abort_ff);
  c_bad_unlock: cover property (seq_ff == SEQ_GOT_KEY1 ##1
    seq_ff == SEQ_IDLE);

endmodule // deac_ctrl

// ===== logic/deac_pkg.sv
package deac_pkg;

  // ----------------------------------------------------------------
  // bus and register map (word index, byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int        ADDR_W     = 12;
  localparam int        DATA_W     = 32;
  localparam int        IDX_W      = 8;
  localparam logic [7:0] IDX_FLAGS  = 8'h0C;
  localparam logic [7:0] IDX_IRQEN  = 8'h8C;
  localparam logic [7:0] IDX_DATA   = 8'h9A;
  localparam logic [7:0] IDX_INDEX  = 8'h9B;
  localparam logic [7:0] IDX_CTRL   = 8'h9C;
  localparam logic [7:0] IDX_UNLOCK = 8'h9D;

  // ----------------------------------------------------------------
  // storage and field layout
  // ----------------------------------------------------------------
  localparam int         CELL_COUNT   = 128;
  localparam int         CELL_AW      = 7;
  localparam int         FETCH_BIT    = 0;
  localparam int         PROG_BIT     = 1;
  localparam int         GATE_BIT     = 2;
  localparam int         ABORT_BIT    = 3;
  localparam int         DONE_BIT     = 7;
  localparam int         DONE_IE_BIT  = 7;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam logic [7:0] UNLOCK_KEY1  = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2  = 8'hAA;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROG_TIME_NS  = 5000000;
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CNT_W    = 24;
  localparam int UNLOCK_GAP_NS = 80;
  localparam int UNLOCK_GAP_CYC =
    (UNLOCK_GAP_NS / CLK_PERIOD_NS) < 1 ? 1 : UNLOCK_GAP_NS / CLK_PERIOD_NS;
  localparam int GAP_CNT_W     = 4;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_GOT_KEY1,
    SEQ_GOT_KEY2
  } deac_seq_type;

endpackage

// ===== logic/deac_cell_array.sv
`timescale 1ns/1ps
module deac_cell_array
  import deac_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [CELL_AW-1:0]    rdIndex,
  output logic      [7:0]            rdByte,
  input  wire logic [CELL_AW-1:0]    wrIndex,
  input  wire logic                  eraseEn,
  input  wire logic                  storeEn,
  input  wire logic [7:0]            storeByte
);
  import deac_pkg::*;

  // RULE1: 128 addressable bytes
  logic [7:0] cell_ff [CELL_COUNT];
  logic [7:0] nxt_cell [CELL_COUNT];

  // ----------------------------------------------------------------
  // erase-then-store cell update
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < CELL_COUNT; i++) begin
      nxt_cell[i] = cell_ff[i];
    end
    if (eraseEn) begin
      nxt_cell[wrIndex] = ERASED_BYTE;
    end
    if (storeEn) begin
      nxt_cell[wrIndex] = storeByte;
    end
  end

  // nonvolatile contents survive system reset
  always_ff @(posedge clock) begin
    for (int i = 0; i < CELL_COUNT; i++) begin
      cell_ff[i] <= nxt_cell[i];
    end
  end

  assign rdByte = cell_ff[rdIndex];

endmodule // deac_cell_array

// ===== test/deac_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// cpu side register bus master
// ----------------------------------------------------------------
module deac_cpu_model (
  input  wire logic                       clock,
  output logic                            psel,
  output logic                            penable,
  output logic                            pwrite,
  output logic [deac_pkg::ADDR_W-1:0]     paddr,
  output logic [deac_pkg::DATA_W-1:0]     pwdata,
  output logic [3:0]                      pstrb,
  input  wire logic [deac_pkg::DATA_W-1:0] prdata,
  input  wire logic                       pready,
  input  wire logic                       pslverr,
  output logic                            hung
);
  import deac_pkg::*;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = 4'h0;
    hung    = 1'b0;
  end

  // one transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d, output logic [DATA_W-1:0] r,
                      output logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    pstrb   <= 4'hF;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    hung = hung | (n >= 40);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // two keys then the trigger write
  task automatic start_prog(input logic [7:0] k1, input logic [7:0] k2,
                            input logic [7:0] ctl);
    logic [DATA_W-1:0] r;
    logic              e;
    xfer(1'b1, {2'b00, IDX_UNLOCK, 2'b00}, k1, r, e);
    xfer(1'b1, {2'b00, IDX_UNLOCK, 2'b00}, k2, r, e);
    xfer(1'b1, {2'b00, IDX_CTRL, 2'b00}, ctl, r, e);
  endtask
endmodule // deac_cpu_model

// ===== test/deac_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin \
  nMismatch++; $display("wrong value %s exp %0h got %0h", nm, ex, got); \
  end end
module deac_ctrl_test;
  import deac_pkg::*;
  localparam int PCYC = 20;
  localparam logic [11:0] A_FLG = {2'b00, IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_IEN = {2'b00, IDX_IRQEN, 2'b00};
  localparam logic [11:0] A_DAT = {2'b00, IDX_DATA, 2'b00};
  localparam logic [11:0] A_IDX = {2'b00, IDX_INDEX, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] A_UNL = {2'b00, IDX_UNLOCK, 2'b00};

  logic        clock, rst, resetMasterClear, resetWatchdog, codeProtect;
  logic        psel, penable, pwrite, pready, pslverr, hung;
  logic        peripheralIrq, programBusy, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb;
  logic [6:0]  extIndex;
  logic [7:0]  extByte;
  int          nMismatch, testsRun;

  deac_ctrl #(.PROG_CYC(PCYC)) u_deac_ctrl (
    .clock(clock), .rst(rst), .resetMasterClear(resetMasterClear),
    .resetWatchdog(resetWatchdog),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .peripheralIrq(peripheralIrq),
    .programBusy(programBusy), .codeProtect(codeProtect),
    .extIndex(extIndex), .extByte(extByte));

  deac_cpu_model u_deac_cpu_model (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hung(hung));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (nMismatch == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    u_deac_cpu_model.xfer(w, a, d, rdv, errv);
    if (hung !== 1'b0) begin
      nMismatch++;
      end_sim();
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex,
                        input string nm);
    bus(1'b0, a, 8'h00);
    `CHK(nm, ex, rdv)
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    while (programBusy !== 1'b0 && n < PCYC + 20) begin
      @(negedge clock);
      n++;
    end
    if (n >= PCYC + 20) begin
      nMismatch++;
      end_sim();
    end
    @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic scen_reset();
    logic [11:0] adr [6];
    adr = '{A_FLG, A_IEN, A_DAT, A_IDX, A_CTL, A_UNL};
    foreach (adr[i]) rd_chk(adr[i], 32'h0, "resetVal");
    bus(1'b1, A_UNL, 8'h3C);
    rd_chk(A_UNL, 32'h0, "unlockRead");
    bus(1'b0, 12'h004, 8'h00);
    `CHK("unmappedErr", 1'b1, errv)
  endtask

  task automatic scen_program();
    int n;
    bus(1'b1, A_IEN, 8'h80);
    bus(1'b1, A_IDX, 8'h85);
    rd_chk(A_IDX, 32'h05, "indexTop");
    bus(1'b1, A_DAT, 8'h3C);
    bus(1'b1, A_CTL, 8'hF4);
    rd_chk(A_CTL, 32'h04, "ctrlUpper");
    u_deac_cpu_model.start_prog(8'h55, 8'hAA, 8'h06);
    `CHK("busyOn", 1'b1, programBusy)
    wait_idle(n);
    `CHK("busyLen", PCYC, n)
    rd_chk(A_FLG, 32'h80, "doneFlag");
    `CHK("irqOn", 1'b1, peripheralIrq)
    rd_chk(A_CTL, 32'h04, "progClear");
    bus(1'b1, A_DAT, 8'h00);
    bus(1'b1, A_CTL, 8'h05);
    rd_chk(A_DAT, 32'h3C, "readBack");
    rd_chk(A_CTL, 32'h04, "fetchClear");
    extIndex <= 7'h05;
    codeProtect <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK("extOpen", 8'h3C, extByte)
    codeProtect <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK("extShut", 8'h00, extByte)
    bus(1'b1, A_FLG, 8'h00);
    rd_chk(A_FLG, 32'h0, "doneClr");
    `CHK("irqOff", 1'b0, peripheralIrq)
  endtask

  task automatic scen_blocked();
    bus(1'b1, A_CTL, 8'h00);
    u_deac_cpu_model.start_prog(8'h55, 8'hAA, 8'h02);
    `CHK("noGateBusy", 1'b0, programBusy)
    rd_chk(A_CTL, 32'h0, "noGateCtl");
    bus(1'b1, A_CTL, 8'h04);
    u_deac_cpu_model.start_prog(8'hAA, 8'h55, 8'h06);
    `CHK("badSeqBusy", 1'b0, programBusy)
    rd_chk(A_CTL, 32'h04, "badSeqCtl");
  endtask

  task automatic scen_abort(input logic wdt);
    bus(1'b1, A_IDX, 8'h11);
    bus(1'b1, A_DAT, 8'h5A);
    bus(1'b1, A_CTL, 8'h04);
    u_deac_cpu_model.start_prog(8'h55, 8'hAA, 8'h06);
    bus(1'b1, A_CTL, 8'h05);
    rd_chk(A_CTL, 32'h06, "busyCtl");
    rd_chk(A_DAT, 32'h5A, "busyData");
    `CHK("stillBusy", 1'b1, programBusy)
    resetMasterClear <= ~wdt;
    resetWatchdog <= wdt;
    @(posedge clock);
    resetMasterClear <= 1'b0;
    resetWatchdog <= 1'b0;
    @(posedge clock);
    rd_chk(A_CTL, 32'h08, "abortFlag");
    rd_chk(A_DAT, 32'h0, "abortData");
    rd_chk(A_IDX, 32'h0, "abortIndex");
    extIndex <= 7'h11;
    codeProtect <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK("erasedCell", ERASED_BYTE, extByte)
    bus(1'b1, A_CTL, 8'h00);
    rd_chk(A_CTL, 32'h0, "abortClr");
  endtask

  initial begin
    nMismatch = 0;
    testsRun = 0;
    rst = 1'b1;
    resetMasterClear = 1'b0;
    resetWatchdog = 1'b0;
    codeProtect = 1'b0;
    extIndex = 7'h00;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    scen_reset();
    scen_program();
    scen_blocked();
    scen_abort(1'b0);
    scen_abort(1'b1);
    end_sim();
  end
endmodule // deac_ctrl_test
